/* hw/pim_map.svh */
// Purpose: constants for the pair/indirect/immediate move decoder
// Assumes: one clock domain, instruction bytes arrive from the fetch stage on that clock
// Notes: opcode values, field positions, widths and reset values for pim_core live here; the tb files repeat opcodes and field positions as literals
`ifndef PIM_MAP_SVH
`define PIM_MAP_SVH

// opcode bytes
`define PIM_OP_LD_PAIR_B 8'h06
`define PIM_OP_LD_PAIR_A 8'h04
`define PIM_OP_IMM_PAIR_A 8'h50
`define PIM_OP_IMM_PAIR_B 8'h52

// immediate byte split
`define PIM_IMM_HI_MSB 7
`define PIM_IMM_HI_LSB 4
`define PIM_IMM_LO_MSB 3
`define PIM_IMM_LO_LSB 0

// data ram geometry and pair address split
`define PIM_RAM_ADDR_W 7
`define PIM_RAM_DEPTH 128
`define PIM_PAIR_HI_BITS 3

// reset values
`define PIM_NIB_RST 4'h0
`define PIM_BYTE_RST 8'h00
`define PIM_ADDR_RST 7'h00

// read latency of the ram in cycles
`define PIM_RAM_LAT 1

`endif

/* hw/pim_pkg.sv */
// Purpose: shared types of the pair/indirect/immediate move decoder
// Assumes: pim_map.svh holds the numeric constants except the state and pair encodings below
// Notes: states use gray codes along idle -> operand / idle -> memory wait
package pim_pkg;

	typedef logic [3:0] pim_nib_t;
	typedef logic [7:0] pim_byte_t;

	typedef enum logic [1:0] {
		PIM_ST_IDLE    = 2'b00,
		PIM_ST_OPERAND = 2'b01,
		PIM_ST_MEMWAIT = 2'b10
	} pim_state_t;

	// which pair an immediate operand byte is destined for
	typedef enum logic {
		PIM_DST_PAIR_A = 1'b0,
		PIM_DST_PAIR_B = 1'b1
	} pim_dst_t;

endpackage

/* hw/pim_ram.sv */
// Purpose: nibble-wide data ram with one write port and a registered read port
// Assumes: single clock, write and read may share a cycle
// Notes: read data appear one edge after the address; a same-cycle write is not forwarded
`timescale 1ns/1ps
`default_nettype none
module pim_ram #(
	parameter int ADDR_W = 7,
	parameter int DEPTH  = 128,
	parameter int DATA_W = 4
) (
	input  wire logic              clk_in,
	input  wire logic              wr_en_in,
	input  wire logic [ADDR_W-1:0] wr_addr_in,
	input  wire logic [DATA_W-1:0] wr_data_in,
	input  wire logic              rd_en_in,
	input  wire logic [ADDR_W-1:0] rd_addr_in,
	output logic      [DATA_W-1:0] rd_data_out
);

	logic [DATA_W-1:0] mem_r [DEPTH];
	logic [DATA_W-1:0] rd_data_r;

	// storage has no reset; contents are loaded from outside before use
	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem_r[wr_addr_in] <= wr_data_in;
		end
		if (rd_en_in) begin
			rd_data_r <= mem_r[rd_addr_in];
		end
	end

	assign rd_data_out = rd_data_r;

endmodule // pim_ram
`default_nettype wire

/* hw/pim_core.sv */
// Purpose: decode and execute indirect accumulator loads and two-byte pair immediates
// Assumes: bytes come from the fetch stage on clk_in with a valid/ready handshake
// Notes: other opcodes are consumed and flagged, never executed here
//        the ram address is the low seven bits of a pair, so its top bit is ignored
//        an indirect load costs one refused cycle while the registered ram read settles
//        an immediate opcode always claims the next taken byte as its operand
`timescale 1ns/1ps
`default_nettype none
`include "pim_map.svh"
module pim_core #(
	parameter int RAM_ADDR_W = `PIM_RAM_ADDR_W,
	parameter int RAM_DEPTH  = `PIM_RAM_DEPTH
) (
	input  wire logic                  clk_in,
	input  wire logic                  arst_n_in,
	// instruction byte stream
	input  wire logic                  instr_valid_in,
	input  wire logic [7:0]            instr_byte_in,
	output logic                       instr_ready_out,
	// data ram load port
	input  wire logic                  ram_wr_en_in,
	input  wire logic [RAM_ADDR_W-1:0] ram_wr_addr_in,
	input  wire logic [3:0]            ram_wr_data_in,
	// architectural state
	output logic      [3:0]            accumulator_nibble_out,
	output logic      [3:0]            work_reg_zero_out,
	output logic      [3:0]            work_reg_one_out,
	output logic      [3:0]            work_reg_two_out,
	output logic      [3:0]            work_reg_three_out,
	// status pulses
	output logic                       exec_done_out,
	output logic                       unsupported_out
);

	// reset release through two flops; assert is asynchronous
	// synchronous release keeps every state flop leaving reset on one edge
	logic rst_meta_r;
	logic rst_sync_n_r;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_meta_r   <= 1'b0;
			rst_sync_n_r <= 1'b0;
		end else begin
			rst_meta_r   <= 1'b1;
			rst_sync_n_r <= rst_meta_r;
		end
	end

	// decode of the byte on offer
	logic is_ld_a;
	logic is_ld_b;
	logic is_imm_a;
	logic is_imm_b;

	assign is_ld_b  = (instr_byte_in == `PIM_OP_LD_PAIR_B);
	assign is_ld_a  = (instr_byte_in == `PIM_OP_LD_PAIR_A);
	assign is_imm_a = (instr_byte_in == `PIM_OP_IMM_PAIR_A);
	assign is_imm_b = (instr_byte_in == `PIM_OP_IMM_PAIR_B);

	// sequencer and architectural state
	pim_pkg::pim_state_t state_r;
	pim_pkg::pim_state_t state_nxt;
	pim_pkg::pim_dst_t   dst_r;
	pim_pkg::pim_dst_t   dst_nxt;
	pim_pkg::pim_nib_t   acc_r;
	pim_pkg::pim_nib_t   acc_nxt;
	pim_pkg::pim_nib_t   r0_r;
	pim_pkg::pim_nib_t   r0_nxt;
	pim_pkg::pim_nib_t   r1_r;
	pim_pkg::pim_nib_t   r1_nxt;
	pim_pkg::pim_nib_t   r2_r;
	pim_pkg::pim_nib_t   r2_nxt;
	pim_pkg::pim_nib_t   r3_r;
	pim_pkg::pim_nib_t   r3_nxt;

	// handshake and status pulse flops
	logic                ready_r;
	logic                ready_nxt;
	logic                done_r;
	logic                done_nxt;
	logic                unsup_r;
	logic                unsup_nxt;
	logic                take;

	// ram read request is combinational so data land one edge later
	logic                  rd_en;
	logic [RAM_ADDR_W-1:0] rd_addr;
	pim_pkg::pim_nib_t     rd_data;
	logic [7:0]            pair_a_addr;
	logic [7:0]            pair_b_addr;

	// pair addresses and the byte handshake
	assign pair_a_addr = {r1_r, r0_r};
	assign pair_b_addr = {r3_r, r2_r};
	assign take        = instr_valid_in && ready_r;

	// data ram: loaded from outside, read only by the indirect loads
	pim_ram #(
		.ADDR_W (RAM_ADDR_W),
		.DEPTH  (RAM_DEPTH),
		.DATA_W (4)
	) u_ram (
		.clk_in      (clk_in),
		.wr_en_in    (ram_wr_en_in),
		.wr_addr_in  (ram_wr_addr_in),
		.wr_data_in  (ram_wr_data_in),
		.rd_en_in    (rd_en),
		.rd_addr_in  (rd_addr),
		.rd_data_out (rd_data)
	);

	// next-state logic for sequencer, registers and status pulses
	always_comb begin
		// hold by default; pulses and the read strobe idle low
		state_nxt = state_r;
		dst_nxt   = dst_r;
		acc_nxt   = acc_r;
		r0_nxt    = r0_r;
		r1_nxt    = r1_r;
		r2_nxt    = r2_r;
		r3_nxt    = r3_r;
		done_nxt  = 1'b0;
		unsup_nxt = 1'b0;
		rd_en     = 1'b0;
		rd_addr   = pair_a_addr[RAM_ADDR_W-1:0];
		case (state_r)
			pim_pkg::PIM_ST_IDLE: begin
				// opcode byte: start an indirect load or arm the operand state
				if (take) begin
					if (is_ld_b) begin
						// only the low ram address bits exist; upper pair bits are ignored
						rd_en     = 1'b1;
						rd_addr   = pair_b_addr[RAM_ADDR_W-1:0];
						state_nxt = pim_pkg::PIM_ST_MEMWAIT;
					end else if (is_ld_a) begin
						rd_en     = 1'b1;
						rd_addr   = pair_a_addr[RAM_ADDR_W-1:0];
						state_nxt = pim_pkg::PIM_ST_MEMWAIT;
					end else if (is_imm_a) begin
						dst_nxt   = pim_pkg::PIM_DST_PAIR_A;
						state_nxt = pim_pkg::PIM_ST_OPERAND;
					end else if (is_imm_b) begin
						dst_nxt   = pim_pkg::PIM_DST_PAIR_B;
						state_nxt = pim_pkg::PIM_ST_OPERAND;
					end else begin
						unsup_nxt = 1'b1; // consumed, not executed here
					end
				end
			end
			pim_pkg::PIM_ST_OPERAND: begin
				// second byte carries the whole 8-bit immediate
				if (take) begin
					if (dst_r == pim_pkg::PIM_DST_PAIR_A) begin
						r1_nxt = instr_byte_in[`PIM_IMM_HI_MSB:`PIM_IMM_HI_LSB];
						r0_nxt = instr_byte_in[`PIM_IMM_LO_MSB:`PIM_IMM_LO_LSB];
					end else begin
						r3_nxt = instr_byte_in[`PIM_IMM_HI_MSB:`PIM_IMM_HI_LSB];
						r2_nxt = instr_byte_in[`PIM_IMM_LO_MSB:`PIM_IMM_LO_LSB];
					end
					done_nxt  = 1'b1;
					state_nxt = pim_pkg::PIM_ST_IDLE;
				end
			end
			pim_pkg::PIM_ST_MEMWAIT: begin
				// registered ram data are valid now
				acc_nxt   = rd_data;
				done_nxt  = 1'b1;
				state_nxt = pim_pkg::PIM_ST_IDLE;
			end
			default: begin
				// unused encoding falls back to idle
				state_nxt = pim_pkg::PIM_ST_IDLE;
			end
		endcase
		// stall the fetch stage while the ram answer is outstanding
		ready_nxt = (state_nxt != pim_pkg::PIM_ST_MEMWAIT);
	end

	// state, handshake and status pulse registers
	always_ff @(posedge clk_in or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			state_r <= pim_pkg::PIM_ST_IDLE;
			dst_r   <= pim_pkg::PIM_DST_PAIR_A;
			acc_r   <= `PIM_NIB_RST;
			r0_r    <= `PIM_NIB_RST;
			r1_r    <= `PIM_NIB_RST;
			r2_r    <= `PIM_NIB_RST;
			r3_r    <= `PIM_NIB_RST;
			ready_r <= 1'b0;
			done_r  <= 1'b0;
			unsup_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			dst_r   <= dst_nxt;
			acc_r   <= acc_nxt;
			r0_r    <= r0_nxt;
			r1_r    <= r1_nxt;
			r2_r    <= r2_nxt;
			r3_r    <= r3_nxt;
			ready_r <= ready_nxt;
			done_r  <= done_nxt;
			unsup_r <= unsup_nxt;
		end
	end

	// all outputs straight from flops
	assign instr_ready_out        = ready_r;

	// architectural state
	assign accumulator_nibble_out = acc_r;
	assign work_reg_zero_out      = r0_r;
	assign work_reg_one_out       = r1_r;
	assign work_reg_two_out       = r2_r;
	assign work_reg_three_out     = r3_r;

	// one-cycle status pulses
	assign exec_done_out          = done_r;
	assign unsupported_out        = unsup_r;

endmodule // pim_core
`default_nettype wire

/* tb/pim_core_properties.sv */
// Purpose: temporal checks on the pim_core ports
// Assumes: bound to every pim_core instance
// Notes: helper logic tracks whether the next taken byte is an operand
`timescale 1ns/1ps
`default_nettype none
module pim_core_checker (
	input wire logic       clk_in,
	input wire logic       arst_n_in,
	input wire logic       instr_valid_in,
	input wire logic [7:0] instr_byte_in,
	input wire logic       instr_ready_out,
	input wire logic [3:0] work_reg_zero_out,
	input wire logic [3:0] work_reg_one_out,
	input wire logic [3:0] work_reg_two_out,
	input wire logic [3:0] work_reg_three_out,
	input wire logic       exec_done_out
);
	logic tk, opnd_r, opnd_nxt, dst_r, dst_nxt;
	assign tk = instr_valid_in && instr_ready_out;
	// an operand byte never opens a new instruction, whatever its value
	always_comb begin
		opnd_nxt = opnd_r;
		dst_nxt = dst_r;
		if (tk) begin
			opnd_nxt = !opnd_r && (instr_byte_in == 8'h50 || instr_byte_in == 8'h52);
			dst_nxt = instr_byte_in == 8'h52;
		end
	end
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			opnd_r <= 1'b0;
			dst_r <= 1'b0;
		end else begin
			opnd_r <= opnd_nxt;
			dst_r <= dst_nxt;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	// one refused cycle, then the load completes
	sequence ld_seq;
		##1 !instr_ready_out ##1 exec_done_out;
	endsequence
	ld_pair_b_a: assert property (tk && !opnd_r && instr_byte_in == 8'h06 |-> ld_seq)
		else $error("pair b load timing wrong");
	ld_pair_a_a: assert property (tk && !opnd_r && instr_byte_in == 8'h04 |-> ld_seq)
		else $error("pair a load timing wrong");
	imm_done_a: assert property (tk && opnd_r |=> exec_done_out)
		else $error("immediate not completed");
	imm_hi_a: assert property (tk && opnd_r && !dst_r |=>
		work_reg_one_out == $past(instr_byte_in[7:4]))
		else $error("register one wrong");
	imm_lo_a: assert property (tk && opnd_r && !dst_r |=>
		work_reg_zero_out == $past(instr_byte_in[3:0]))
		else $error("register zero wrong");
	imm_pair_b_a: assert property (tk && opnd_r && dst_r |=>
		work_reg_three_out == $past(instr_byte_in[7:4]) &&
		work_reg_two_out == $past(instr_byte_in[3:0]))
		else $error("pair b immediate wrong");
endmodule // pim_core_checker
bind pim_core pim_core_checker pim_core_checker_inst (.clk_in, .arst_n_in, .instr_valid_in,
	.instr_byte_in, .instr_ready_out, .work_reg_zero_out, .work_reg_one_out,
	.work_reg_two_out, .work_reg_three_out, .exec_done_out);
`default_nettype wire

/* tb/pim_fetch_model.sv */
// Purpose: fetch stage model offering one byte at a time
// Assumes: send_in pulses one cycle per byte
// Notes: holds valid and byte until taken
`timescale 1ns/1ps
`default_nettype none
module pim_fetch_model (
	input  wire logic       clk_in,
	input  wire logic       arst_n_in,
	input  wire logic       send_in,
	input  wire logic [7:0] byte_in,
	input  wire logic       ready_in,
	output logic            valid_out,
	output logic      [7:0] byte_out
);
	logic       valid_r, valid_nxt;
	logic [7:0] byte_r, byte_nxt;
	// a released byte turns inverse so a stale value is never taken for live
	always_comb begin
		valid_nxt = valid_r;
		byte_nxt = byte_r;
		if (send_in) begin
			valid_nxt = 1'b1;
			byte_nxt = byte_in;
		end else if (valid_r && ready_in) begin
			valid_nxt = 1'b0;
			byte_nxt = ~byte_r;
		end
	end
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			valid_r <= 1'b0;
			byte_r <= 8'h00;
		end else begin
			valid_r <= valid_nxt;
			byte_r <= byte_nxt;
		end
	end
	assign valid_out = valid_r;
	assign byte_out = byte_r;
endmodule // pim_fetch_model
`default_nettype wire

/* tb/testbench.sv */
// Purpose: self-checking bench for pim_core
// Assumes: expected state kept as {acc, r3, r2, r1, r0}
// Notes: ram mirrored in the bench to predict indirect loads
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk_in, arst_n_in, snd, ram_we, fv, rdy, done, uns;
	logic [7:0]  sb, fb, seed;
	logic [6:0]  ram_a;
	logic [3:0]  ram_d, acc, r0, r1, r2, r3;
	logic [3:0]  mem [128];
	logic [19:0] st;
	logic [19:0] exp_q [$];
	int          err_count, n_tests, uns_n;
	pim_fetch_model pim_fetch_model_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .send_in(snd),
		.byte_in(sb), .ready_in(rdy), .valid_out(fv), .byte_out(fb));
	pim_core #(.RAM_ADDR_W(7), .RAM_DEPTH(128)) pim_core_inst (.clk_in(clk_in),
		.arst_n_in(arst_n_in), .instr_valid_in(fv), .instr_byte_in(fb), .instr_ready_out(rdy),
		.ram_wr_en_in(ram_we), .ram_wr_addr_in(ram_a), .ram_wr_data_in(ram_d),
		.accumulator_nibble_out(acc), .work_reg_zero_out(r0), .work_reg_one_out(r1),
		.work_reg_two_out(r2), .work_reg_three_out(r3), .exec_done_out(done),
		.unsupported_out(uns));
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input string nm, input logic [19:0] s, input logic [19:0] e);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// offer one byte and wait, bounded, until the core has taken it
	task automatic send(input logic [7:0] b);
		int n;
		snd <= 1'b1;
		sb <= b;
		@(posedge clk_in);
		snd <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (fv === 1'b1 && n < 50);
		chk("byte taken", 20'(fv), 20'h0);
	endtask
	task automatic wr(input logic [6:0] a, input logic [3:0] d);
		ram_we <= 1'b1;
		ram_a <= a;
		ram_d <= d;
		mem[a] = d;
		@(posedge clk_in);
		ram_we <= 1'b0;
	endtask
	task automatic imm(input logic [7:0] op, input logic [7:0] v);
		send(op);
		if (op == 8'h50) st[7:0] = v;
		else st[15:8] = v;
		exp_q.push_back(st);
		send(v);
	endtask
	task automatic ld(input logic [7:0] op);
		st[19:16] = mem[op == 8'h06 ? st[14:8] : st[6:0]];
		exp_q.push_back(st);
		send(op);
	endtask
	// each completion is compared against the oldest note
	always @(posedge clk_in) begin
		if (uns === 1'b1) uns_n++;
		if (done === 1'b1) begin
			if (exp_q.size() == 0) chk("spare done", 20'h1, 20'h0);
			else chk("state", {acc, r3, r2, r1, r0}, exp_q.pop_front());
		end
	end
	initial begin
		#40000;
		err_count++;
		test_done();
	end
	initial begin
		arst_n_in = 1'b0;
		snd = 1'b0;
		sb = 8'h00;
		ram_we = 1'b0;
		ram_a = 7'h00;
		ram_d = 4'h0;
		seed = 8'h03;
		st = 20'h00000;
		repeat (3) @(posedge clk_in);
		arst_n_in <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			imm(8'h52, seed);
			wr(seed[6:0], ~seed[7:4]);
			ld(8'h06);
			seed = lfsr(seed);
			imm(8'h50, seed);
			wr(seed[6:0], seed[7:4] ^ seed[3:0]);
			ld(8'h04);
		end
		$display("test pair loads done");
		imm(8'h50, 8'h06);
		send(8'h3e);
		wr(7'h06, 4'h9);
		ld(8'h04);
		repeat (4) @(posedge clk_in);
		chk("unsupported", 20'(uns_n), 20'h1);
		chk("pending", 20'(exp_q.size()), 20'h0);
		$display("test operand and unsupported done");
		test_done();
	end
endmodule // testbench
`default_nettype wire
